/* File: tpw_timer.sv */
// 8-bit timer with fast and phase correct pwm waveform generation, axi4-lite registers
// How it works
// [R1] Mode selector 3 or 7 selects fast pwm.
// [R2] Fast pwm top is 0xff for mode 3, compare A for mode 7.
// [R3] Fast pwm counts up to top, then wraps to zero next tick.
// [R4] Fast pwm code 2 clears on match, sets at bottom; code 3 reverse.
// [R5] Fast pwm code 1 toggles channel A on match when top bit set; B never.
// [R6] Fast pwm sets overflow flag when counter reaches top.
// [R7] Fast pwm output changes at match and opposite at the top-to-bottom tick.
// [R8] Fixed-top fast pwm period is 256 ticks of the prescaled tick.
// [R9] Fast compare A zero gives one-tick spike; max gives constant level.
// [R10] Fast pwm compare values double buffered; toggle at zero gives clock/2.
// [R11] Mode 1 or 5 selects phase correct; top 0xff or compare A.
// [R12] Phase correct counts up to top, down to bottom, top held one tick.
// [R13] Phase correct non-inverting clears on up match, sets on down match.
// [R14] Phase correct sets overflow flag when counter reaches bottom.
// [R15] Phase correct code 1 toggles channel A when top bit set; B never.
// [R16] Fixed-top phase correct period is 510 ticks.
// [R17] Phase correct compare zero holds low, max holds high (non-inverting).
// [R18] Phase correct output forced at bottom so waveform stays symmetric.
// [R19] All logic on the i/o clock; tick only enables counting, flags, compare buffer loads and waveform updates.
// [R20] Action code 0 disconnects the pin from the waveform output.
// [R21] Fast pwm: compare equal top with code bit 1 set acts at bottom only.
// [R22] Software counter write blocks any match in the next tick.
// [R23] Match flag set on tick where counter equals compare value.
// [R24] Buffered compare values load into active values at the mode update point.
`timescale 1ns/100ps
`default_nettype none
module tpw_timer (
	// clock, reset, enable
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	// prescaled timer tick, same clock domain
	input wire logic TIMER_TICK,
	// axi4-lite slave
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// waveform pins and flags
	output tpw_pkg::tpw_wave_t WAVE_PINS,
	output tpw_pkg::tpw_flags_t FLAGS
);
	import tpw_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0] waveform_mode_sel;
		logic [1:0] output_action_sel_a;
		logic [1:0] output_action_sel_b;
		logic [7:0] count_value;
		logic [7:0] compare_value_a;
		logic [7:0] compare_value_b;
		logic [7:0] active_a;
		logic [7:0] active_b;
		logic count_down;
		logic block_match;
		logic wave_a;
		logic wave_b;
		tpw_flags_t flags;
		logic have_aw;
		logic [7:0] aw_addr;
		logic have_w;
		logic [7:0] w_byte;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} tpw_state_t;

	tpw_state_t st_r;
	tpw_state_t st_nxt;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic tpw_is_fast(input logic [2:0] m);
		return (m == TPW_MODE_FAST_FIX) || (m == TPW_MODE_FAST_VAR); // [R1]
	endfunction

	function automatic logic tpw_is_pc(input logic [2:0] m);
		return (m == TPW_MODE_PC_FIX) || (m == TPW_MODE_PC_VAR); // [R11]
	endfunction

	// level that a pwm action code drives on an up match (fast: on any match)
	function automatic logic tpw_match_level(input logic [1:0] act, input logic cur);
		return (act == TPW_ACT_NONINV) ? 1'b0 : (act == TPW_ACT_INV) ? 1'b1 : cur;
	endfunction

	// true when a channel's code is connected to the pin
	function automatic logic tpw_connected(input logic [1:0] act, input logic top_bit, input logic chan_a);
		return act[1] || (chan_a && top_bit && act == TPW_ACT_TOGGLE); // [R20]
	endfunction

	// next level of one channel on a counting tick
	function automatic logic tpw_wave_step(
		input logic fast,
		input logic pc,
		input logic [1:0] act,
		input logic can_toggle,
		input logic cur,
		input logic hit,
		input logic at_top,
		input logic at_bottom_turn,
		input logic cmp_is_top,
		input logic cmp_is_zero,
		input logic down
	);
		logic lvl;
		lvl = cur;
		if (act == TPW_ACT_TOGGLE) begin
			if (can_toggle && hit)
				lvl = ~cur; // [R5] [R15] [R10]
		end else if (act[1] && fast) begin
			if (at_top)
				lvl = ~tpw_match_level(act, cur); // [R4] [R7] [R21]
			else if (hit && !cmp_is_top)
				lvl = tpw_match_level(act, cur); // [R4] [R7]
		end else if (act[1] && pc) begin
			if (cmp_is_top && at_top)
				lvl = ~tpw_match_level(act, cur); // [R17]
			else if (at_bottom_turn)
				lvl = cmp_is_zero ? tpw_match_level(act, cur) : ~tpw_match_level(act, cur); // [R18] [R17]
			else if (hit && !cmp_is_top)
				lvl = down ? ~tpw_match_level(act, cur) : tpw_match_level(act, cur); // [R13]
		end
		return lvl;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	logic fast;
	logic pc;
	logic [7:0] top_val;
	logic tick;
	logic at_top;
	logic at_bottom_turn;
	logic hit_a;
	logic hit_b;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_ok;
	// ****************************************
	// flag set events of this cycle
	// ****************************************
	logic ev_ovf;
	logic ev_ma;
	logic ev_mb;

	always_comb begin
		st_nxt = st_r;
		fast = tpw_is_fast(st_r.waveform_mode_sel);
		pc = tpw_is_pc(st_r.waveform_mode_sel);
		// variable top always follows the active (buffered) compare A
		top_val = st_r.waveform_mode_sel[2] ? st_r.active_a : TPW_FIXED_TOP; // [R2] [R11]
		tick = TIMER_TICK; // [R19]
		at_top = st_r.count_value == top_val;
		at_bottom_turn = pc && st_r.count_down && st_r.count_value == TPW_BOTTOM;
		hit_a = (st_r.count_value == st_r.active_a) && !st_r.block_match; // [R22]
		hit_b = (st_r.count_value == st_r.active_b) && !st_r.block_match; // [R22]
		wr_go = st_r.have_aw && st_r.have_w && !st_r.bvalid;
		rd_go = S_AXI_ARVALID && !st_r.rvalid;
		rd_word = '0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		// a set in the same cycle as a software clear must win
		ev_ovf = tick && ((fast && at_top) || at_bottom_turn); // [R6] [R14]
		ev_ma = tick && (fast || pc) && hit_a; // [R23]
		ev_mb = tick && (fast || pc) && hit_b; // [R23]

		if (tick) begin
			// the block only covers the tick right after a counter write
			st_nxt.block_match = 1'b0; // [R22]
			if (fast) begin
				if (at_top) begin
					st_nxt.count_value = TPW_BOTTOM; // [R3] [R8]
					st_nxt.flags.overflow_flag = 1'b1; // [R6]
					st_nxt.active_a = st_r.compare_value_a; // [R24] [R10]
					st_nxt.active_b = st_r.compare_value_b; // [R24]
				end else begin
					st_nxt.count_value = st_r.count_value + 8'h01; // [R3]
				end
			end else if (pc) begin
				if (st_r.count_down) begin
					if (st_r.count_value == TPW_BOTTOM) begin
						st_nxt.count_down = 1'b0; // [R12]
						st_nxt.count_value = st_r.count_value + 8'h01;
						st_nxt.flags.overflow_flag = 1'b1; // [R14]
					end else begin
						st_nxt.count_value = st_r.count_value - 8'h01; // [R12] [R16]
					end
				end else if (at_top) begin
					// top is held for exactly this one tick before turning
					st_nxt.count_down = 1'b1; // [R12]
					st_nxt.count_value = st_r.count_value - 8'h01;
					st_nxt.active_a = st_r.compare_value_a; // [R24]
					st_nxt.active_b = st_r.compare_value_b; // [R24]
				end else begin
					st_nxt.count_value = st_r.count_value + 8'h01; // [R12]
				end
			end else begin
				// other modes are not built here: counter parked, buffers transparent
				st_nxt.count_down = 1'b0;
				st_nxt.active_a = st_r.compare_value_a;
				st_nxt.active_b = st_r.compare_value_b;
			end
			if ((fast || pc) && hit_a)
				st_nxt.flags.match_flag_a = 1'b1; // [R23]
			if ((fast || pc) && hit_b)
				st_nxt.flags.match_flag_b = 1'b1; // [R23]
			st_nxt.wave_a = tpw_wave_step(
				fast,
				pc,
				st_r.output_action_sel_a,
				st_r.waveform_mode_sel[2],
				st_r.wave_a,
				hit_a,
				at_top,
				at_bottom_turn,
				st_r.active_a == top_val,
				st_r.active_a == TPW_BOTTOM,
				st_r.count_down
			); // [R9]
			// channel b never toggles, so its toggle permission is tied off
			st_nxt.wave_b = tpw_wave_step(
				fast,
				pc,
				st_r.output_action_sel_b,
				1'b0,
				st_r.wave_b,
				hit_b,
				at_top,
				at_bottom_turn,
				st_r.active_b == top_val,
				st_r.active_b == TPW_BOTTOM,
				st_r.count_down
			);
		end

		// ****************************************
		// register bus
		// ****************************************

		// write address and data are taken independently
		if (S_AXI_AWVALID && !st_r.have_aw && !st_r.bvalid) begin
			st_nxt.have_aw = 1'b1;
			st_nxt.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !st_r.have_w && !st_r.bvalid) begin
			st_nxt.have_w = 1'b1;
			// all fields live in byte lane 0; a cleared strobe writes TPW_RESET_BYTE (zero) instead
			st_nxt.w_byte = S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : TPW_RESET_BYTE;
		end
		if (wr_go) begin
			st_nxt.have_aw = 1'b0;
			st_nxt.have_w = 1'b0;
			st_nxt.bvalid = 1'b1;
			unique case (st_r.aw_addr)
				TPW_OFF_CTRL: begin
					st_nxt.waveform_mode_sel = st_r.w_byte[TPW_CTRL_MODE_LSB +: 3];
					st_nxt.output_action_sel_a = st_r.w_byte[TPW_CTRL_ACTA_LSB +: 2];
					st_nxt.output_action_sel_b = st_r.w_byte[TPW_CTRL_ACTB_LSB +: 2];
				end
				TPW_OFF_COUNT: begin
					// software wins over a tick in the same cycle
					st_nxt.count_value = st_r.w_byte;
					st_nxt.block_match = 1'b1; // [R22]
				end
				TPW_OFF_CMPA: begin
					st_nxt.compare_value_a = st_r.w_byte; // [R10]
				end
				TPW_OFF_CMPB: begin
					st_nxt.compare_value_b = st_r.w_byte; // [R10]
				end
				TPW_OFF_FLAGS: begin
					// write one to clear; a flag set in this same cycle survives
					if (st_r.w_byte[TPW_FLG_OVF] && !ev_ovf)
						st_nxt.flags.overflow_flag = 1'b0;
					if (st_r.w_byte[TPW_FLG_MA] && !ev_ma)
						st_nxt.flags.match_flag_a = 1'b0;
					if (st_r.w_byte[TPW_FLG_MB] && !ev_mb)
						st_nxt.flags.match_flag_b = 1'b0;
				end
				TPW_OFF_ACTIVE: begin
					wr_ok = 1'b1;
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			st_nxt.bresp = wr_ok ? TPW_RESP_OKAY : TPW_RESP_SLVERR;
		end
		if (st_r.bvalid && S_AXI_BREADY)
			st_nxt.bvalid = 1'b0;

		if (rd_go) begin
			unique case (S_AXI_ARADDR)
				TPW_OFF_CTRL: begin
					rd_word[TPW_CTRL_MODE_LSB +: 3] = st_r.waveform_mode_sel;
					rd_word[TPW_CTRL_ACTA_LSB +: 2] = st_r.output_action_sel_a;
					rd_word[TPW_CTRL_ACTB_LSB +: 2] = st_r.output_action_sel_b;
				end
				TPW_OFF_COUNT: begin
					rd_word[7:0] = st_r.count_value;
				end
				TPW_OFF_CMPA: begin
					rd_word[7:0] = st_r.compare_value_a;
				end
				TPW_OFF_CMPB: begin
					rd_word[7:0] = st_r.compare_value_b;
				end
				TPW_OFF_FLAGS: begin
					rd_word[TPW_FLG_OVF] = st_r.flags.overflow_flag;
					rd_word[TPW_FLG_MA] = st_r.flags.match_flag_a;
					rd_word[TPW_FLG_MB] = st_r.flags.match_flag_b;
				end
				TPW_OFF_ACTIVE: begin
					rd_word[7:0] = st_r.active_a;
					rd_word[TPW_ACT_B_LSB +: 8] = st_r.active_b;
					rd_word[TPW_ACT_DIR] = st_r.count_down;
				end
				default: rd_ok = 1'b0;
			endcase
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_word;
			st_nxt.rresp = rd_ok ? TPW_RESP_OKAY : TPW_RESP_SLVERR;
		end
		if (st_r.rvalid && S_AXI_RREADY)
			st_nxt.rvalid = 1'b0;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			st_r <= '0;
		else if (CLK_EN)
			st_r <= st_nxt;
	end

	// ****************************************
	// outputs
	// ****************************************
	// readies are gated so a frozen block never accepts an address or write data
	assign S_AXI_AWREADY = CLK_EN && !st_r.have_aw && !st_r.bvalid;
	assign S_AXI_WREADY = CLK_EN && !st_r.have_w && !st_r.bvalid;
	assign S_AXI_ARREADY = CLK_EN && !st_r.rvalid;
	assign S_AXI_BVALID = st_r.bvalid;
	assign S_AXI_BRESP = st_r.bresp;
	assign S_AXI_RVALID = st_r.rvalid;
	assign S_AXI_RDATA = st_r.rdata;
	assign S_AXI_RRESP = st_r.rresp;
	assign WAVE_PINS.out_a = st_r.wave_a;
	assign WAVE_PINS.out_b = st_r.wave_b;
	assign WAVE_PINS.en_a = tpw_connected(st_r.output_action_sel_a, st_r.waveform_mode_sel[2], 1'b1); // [R20]
	assign WAVE_PINS.en_b = tpw_connected(st_r.output_action_sel_b, st_r.waveform_mode_sel[2], 1'b0); // [R20]
	assign FLAGS = st_r.flags;
endmodule // tpw_timer
`default_nettype wire

/* File: tpw_pkg.sv */
// shared constants and carrier types for the 8-bit pwm waveform timer
`default_nettype none
package tpw_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] TPW_OFF_CTRL = 8'h00;
	localparam logic [7:0] TPW_OFF_COUNT = 8'h04;
	localparam logic [7:0] TPW_OFF_CMPA = 8'h08;
	localparam logic [7:0] TPW_OFF_CMPB = 8'h0c;
	localparam logic [7:0] TPW_OFF_FLAGS = 8'h10;
	localparam logic [7:0] TPW_OFF_ACTIVE = 8'h14;

	// ****************************************
	// fields and values
	// ****************************************
	localparam int TPW_CTRL_MODE_LSB = 0;
	localparam int TPW_CTRL_ACTA_LSB = 4;
	localparam int TPW_CTRL_ACTB_LSB = 6;
	localparam int TPW_FLG_OVF = 0;
	localparam int TPW_FLG_MA = 1;
	localparam int TPW_FLG_MB = 2;
	localparam int TPW_ACT_B_LSB = 8;
	localparam int TPW_ACT_DIR = 16;
	localparam logic [2:0] TPW_MODE_PC_FIX = 3'h1;
	localparam logic [2:0] TPW_MODE_FAST_FIX = 3'h3;
	localparam logic [2:0] TPW_MODE_PC_VAR = 3'h5;
	localparam logic [2:0] TPW_MODE_FAST_VAR = 3'h7;
	localparam logic [1:0] TPW_ACT_OFF = 2'h0;
	localparam logic [1:0] TPW_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TPW_ACT_NONINV = 2'h2;
	localparam logic [1:0] TPW_ACT_INV = 2'h3;
	localparam logic [7:0] TPW_FIXED_TOP = 8'hff;
	localparam logic [7:0] TPW_BOTTOM = 8'h00;
	localparam logic [7:0] TPW_RESET_BYTE = 8'h00;
	localparam logic [1:0] TPW_RESP_OKAY = 2'h0;
	localparam logic [1:0] TPW_RESP_SLVERR = 2'h2;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic out_a;
		logic en_a;
		logic out_b;
		logic en_b;
	} tpw_wave_t;

	typedef struct packed {
		logic overflow_flag;
		logic match_flag_a;
		logic match_flag_b;
	} tpw_flags_t;
endpackage
`default_nettype wire

/* File: tpw_timer_sva.sv */
// port assertions for the pwm waveform timer
`timescale 1ns/100ps
`default_nettype none
module tpw_chk (
	// clock and enables
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic TIMER_TICK,
	// bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// waveform and flags
	input wire tpw_pkg::tpw_wave_t WAVE_PINS,
	input wire tpw_pkg::tpw_flags_t FLAGS
);
	import tpw_pkg::*;
	wire logic tk;
	assign tk = TIMER_TICK & CLK_EN;
	default clocking dc @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_wr;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_rd;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	a_ovf_on_tick: assert property ($rose(FLAGS.overflow_flag) |-> $past(tk))
		else $error("overflow flag rose without a tick");
	a_ma_on_tick: assert property ($rose(FLAGS.match_flag_a) |-> $past(tk))
		else $error("match flag a rose without a tick");
	a_mb_on_tick: assert property ($rose(FLAGS.match_flag_b) |-> $past(tk))
		else $error("match flag b rose without a tick");
	a_wave_on_tick: assert property ($changed({WAVE_PINS.out_a, WAVE_PINS.out_b}) |-> $past(tk))
		else $error("waveform moved without a tick");
	a_wr_answer: assert property (s_wr |=> ##1 S_AXI_BVALID)
		else $error("write response late");
	a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	a_rd_answer: assert property (s_rd |=> S_AXI_RVALID)
		else $error("read response late");
	a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("address taken during read response");
	a_freeze_ready: assert property (!CLK_EN |-> !(S_AXI_AWREADY || S_AXI_WREADY || S_AXI_ARREADY))
		else $error("ready while frozen");
endmodule // tpw_chk
bind tpw_timer tpw_chk chk_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .TIMER_TICK(TIMER_TICK),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.WAVE_PINS(WAVE_PINS), .FLAGS(FLAGS));
`default_nettype wire

/* File: tpw_timer_bench.sv */
// self-checking bench for the pwm waveform timer
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_bench;
	import tpw_pkg::*;
	typedef struct {int n; int m; int a; int b; int ca; int cb; int ha; int pa; int hb; int pb;} tpw_row_t;
	logic clk = 0, rst = 1, en = 1, tick_r = 0, man_tk = 0, ea, eb;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, rs;
	tpw_wave_t wave;
	tpw_flags_t flags;
	int err_count = 0, n_checks = 0, presc = 0, tcnt = 0;
	logic [7:0] pcs[3] = '{8'hfe, 8'hff, 8'hfe};
	// n, mode, act a, act b, cmp a, cmp b, high a, period a, high b, period b (period 0: constant)
	tpw_row_t rows[10] = '{'{1, 3, 2, 3, 63, 63, 64, 256, 192, 256}, '{2, 3, 2, 2, 0, 255, 1, 256, 1, 0},
		'{1, 3, 3, 2, 255, 128, 0, 0, 129, 256}, '{1, 1, 2, 3, 64, 64, 128, 510, 382, 510},
		'{1, 1, 2, 3, 0, 255, 0, 0, 0, 0}, '{1, 7, 1, 2, 0, 0, 1, 2, 1, 0}, '{1, 7, 1, 2, 9, 4, 10, 20, 5, 10},
		'{1, 5, 1, 2, 4, 2, 8, 16, 4, 8}, '{1, 1, 1, 0, 9, 9, 0, 0, 0, 0}, '{1, 7, 0, 1, 9, 9, 0, 0, 0, 0}};
	tpw_timer uut (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .TIMER_TICK(tick_r),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .WAVE_PINS(wave), .FLAGS(flags));
	always #5 clk = ~clk;
	// presc 0 hands the tick to single steps from the sequence
	always @(posedge clk) begin
		if (presc == 0) tick_r <= man_tk;
		else begin
			tcnt <= (tcnt + 1) % presc;
			tick_r <= ((tcnt + 1) % presc) == 0;
		end
	end
	// ****************
	// tasks
	// ****************
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task tmo;
		err_count++;
		$display("[ERR] %0t wait ran out", $time);
		summarize();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int k;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (bvalid && bready) break;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b1;
		end
		r = bresp;
		bready <= 1'b0;
		if (k == 40) tmo();
		chk(r, er);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (rvalid && rready) break;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b1;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		if (k == 40) tmo();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] v;
		logic [1:0] r;
		rd(a, v, r);
		chk(v & m, e);
	endtask
	task tick;
		@(posedge clk);
		man_tk <= 1'b1;
		@(posedge clk);
		man_tk <= 1'b0;
	endtask
	function automatic logic sig(input bit s);
		return s ? wave.out_a : wave.out_b;
	endfunction
	// finds a rising edge, then counts high cycles over one period; period 0 counts cycles at the constant level instead
	task automatic meas(input bit s, input int n, input int hi, input int per);
		int k;
		int ones;
		logic p;
		ones = 0;
		if (per == 0) begin
			for (k = 0; k < 600 * n; k++) begin
				@(posedge clk);
				#1 ones += (sig(s) === hi[0]);
			end
			chk(ones, 600 * n);
		end else begin
			for (k = 0; k < 3 * per * n; k++) begin
				p = sig(s);
				@(posedge clk);
				#1;
				if (p === 1'b0 && sig(s) === 1'b1) break;
			end
			if (k == 3 * per * n) tmo();
			for (k = 0; k < per * n; k++) begin
				ones += sig(s);
				@(posedge clk);
				#1;
			end
			chk({ones[30:0], sig(s)}, {31'(hi * n), 1'b1});
		end
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(TPW_OFF_CTRL, 32'h0, 32'hffffffff);
		rc(TPW_OFF_FLAGS, 32'h0, 32'hffffffff);
		rd(8'h18, d, rs);
		chk({d, rs}, {32'h0, TPW_RESP_SLVERR});
		wr(TPW_OFF_ACTIVE, 32'h1, TPW_RESP_OKAY);
		wr(8'h18, 32'h1, TPW_RESP_SLVERR);
		$display("reset and bus corners done");
		foreach (rows[r]) begin
			#1 presc = 0;
			wr(TPW_OFF_CTRL, 32'h0, TPW_RESP_OKAY);
			wr(TPW_OFF_CMPA, 32'(rows[r].ca), TPW_RESP_OKAY);
			wr(TPW_OFF_CMPB, 32'(rows[r].cb), TPW_RESP_OKAY);
			wr(TPW_OFF_COUNT, 32'h0, TPW_RESP_OKAY);
			#1 presc = rows[r].n;
			wr(TPW_OFF_CTRL, 32'({rows[r].b[1:0], rows[r].a[1:0], 1'b0, rows[r].m[2:0]}), TPW_RESP_OKAY);
			ea = rows[r].a[1] | (rows[r].a == 1 && rows[r].m[2]);
			eb = rows[r].b[1];
			chk({wave.en_a, wave.en_b}, {ea, eb});
			repeat (520 * rows[r].n) @(posedge clk);
			#1;
			if (ea) meas(1'b1, rows[r].n, rows[r].ha, rows[r].pa);
			if (eb) meas(1'b0, rows[r].n, rows[r].hb, rows[r].pb);
			$display("row %0d done", r);
		end
		#1 presc = 0;
		wr(TPW_OFF_CTRL, 32'h0, TPW_RESP_OKAY);
		wr(TPW_OFF_CMPA, 32'h10, TPW_RESP_OKAY);
		wr(TPW_OFF_CMPB, 32'h80, TPW_RESP_OKAY);
		wr(TPW_OFF_CTRL, 32'h23, TPW_RESP_OKAY);
		wr(TPW_OFF_COUNT, 32'hfe, TPW_RESP_OKAY);
		wr(TPW_OFF_FLAGS, 32'h7, TPW_RESP_OKAY);
		tick;
		rc(TPW_OFF_FLAGS, 32'h0, 32'h1);
		tick;
		rc(TPW_OFF_COUNT, 32'h0, 32'hff);
		rc(TPW_OFF_FLAGS, 32'h1, 32'h1);
		wr(TPW_OFF_COUNT, 32'h10, TPW_RESP_OKAY);
		wr(TPW_OFF_FLAGS, 32'h7, TPW_RESP_OKAY);
		tick;
		rc(TPW_OFF_FLAGS, 32'h0, 32'h2);
		chk(wave.out_a, 1'b1);
		wr(TPW_OFF_COUNT, 32'h0f, TPW_RESP_OKAY);
		tick;
		tick;
		rc(TPW_OFF_FLAGS, 32'h2, 32'h2);
		chk(wave.out_a, 1'b0);
		$display("fast count test done");
		wr(TPW_OFF_CTRL, 32'h21, TPW_RESP_OKAY);
		wr(TPW_OFF_COUNT, 32'h0, TPW_RESP_OKAY);
		repeat (253) tick;
		foreach (pcs[k]) begin
			tick;
			rc(TPW_OFF_COUNT, 32'(pcs[k]), 32'hff);
		end
		rc(TPW_OFF_ACTIVE, 32'h10000, 32'h10000);
		wr(TPW_OFF_COUNT, 32'h1, TPW_RESP_OKAY);
		wr(TPW_OFF_FLAGS, 32'h7, TPW_RESP_OKAY);
		tick;
		tick;
		rc(TPW_OFF_COUNT, 32'h1, 32'hff);
		rc(TPW_OFF_FLAGS, 32'h1, 32'h1);
		@(posedge clk);
		en <= 1'b0;
		tick;
		@(posedge clk);
		en <= 1'b1;
		rc(TPW_OFF_COUNT, 32'h1, 32'hff);
		$display("phase correct count test done");
		summarize();
	end
endmodule // tpw_timer_bench
`default_nettype wire
